// file: hw/akl_byte_window.sv
`timescale 1ns/100ps
// ==========================================================================
// Byte window: NBYTES frame bytes from start, first byte in the MSBs
module akl_byte_window #(
	parameter int FRAME_BYTES = 128,
	parameter int NBYTES = 8
) (
	input wire logic [FRAME_BYTES*8-1:0] frame,
	input wire logic [8:0] start,
	output logic [NBYTES*8-1:0] win
);
	genvar k;
	generate
		for (k = 0; k < NBYTES; k++) begin : g_byte
			wire [9:0] idx = {1'b0, start} + 10'(k);
			wire in_range = idx < 10'(FRAME_BYTES);
			// Bytes past the captured header read as zero rather than wrap
			assign win[(NBYTES-1-k)*8 +: 8] = in_range ? frame[idx*8 +: 8] : 8'h00;
		end
	endgenerate
endmodule

// file: hw/akl_key_fields.sv
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
`include "akl_params.svh"
// ==========================================================================
// Transport and payload part of the security lookup key.
// One key per frame_valid pulse while the enable bit is set, presented one clock later.
module akl_key_fields #(
	parameter int FRAME_BYTES = 128,
	parameter int NUM_RANGES = `AKL_NUM_RANGES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic frame_valid,
	input wire akl_pkg::akl_frame_s frame_info,
	input wire logic [FRAME_BYTES*8-1:0] frame_data,
	output akl_pkg::akl_key_s key_reg,
	output logic key_valid_reg,
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	// ======================================================================
	// Register bus slave
	logic ctrl_enable_reg;
	logic [31:0] key_count_reg;
	logic [2:0] rng_type_reg [NUM_RANGES];
	logic [31:0] rng_bound_reg [NUM_RANGES];
	logic [31:0] readdata_next;

	wire bus_req = avs_read || avs_write;
	// Every access is answered one cycle after it is raised
	wire bus_ack = bus_req && avs_waitrequest;
	wire wr_take = avs_write && !avs_waitrequest;
	wire waitrequest_next = !bus_ack;

	wire hit_ctrl = avs_address == `AKL_REG_CTRL;
	wire hit_count = avs_address == `AKL_REG_KEY_COUNT;
	wire hit_type = avs_address[6:4] == `AKL_REG_RNG_TYPE_BASE >> 4;
	wire hit_bound = avs_address[6:4] == `AKL_REG_RNG_BOUND_BASE >> 4;
	wire [3:0] rng_sel = avs_address[3:0];

	always_comb begin
		readdata_next = 32'h0000_0000;
		if (hit_ctrl) begin
			readdata_next = {31'h0000_0000, ctrl_enable_reg};
		end else if (hit_count) begin
			readdata_next = key_count_reg;
		end else if (hit_type) begin
			readdata_next = {29'h0000_0000, rng_type_reg[rng_sel]};
		end else if (hit_bound) begin
			readdata_next = rng_bound_reg[rng_sel];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= waitrequest_next;
			avs_readdata <= (avs_read && bus_ack) ? readdata_next : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_enable_reg <= `AKL_CTRL_RESET;
		end else if (wr_take && hit_ctrl) begin
			ctrl_enable_reg <= avs_writedata[0];
		end
	end

	genvar r;
	generate
		for (r = 0; r < NUM_RANGES; r++) begin : g_rng_regs
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					rng_type_reg[r] <= akl_pkg::AKL_RNG_OFF;
					rng_bound_reg[r] <= `AKL_RNG_BOUND_RESET;
				end else if (wr_take && rng_sel == 4'(r)) begin
					if (hit_type) begin
						rng_type_reg[r] <= avs_writedata[2:0];
					end
					if (hit_bound) begin
						rng_bound_reg[r] <= avs_writedata;
					end
				end
			end
		end
	endgenerate

	// ======================================================================
	// Frame classification
	wire is_ip = frame_info.is_ipv4 || frame_info.is_ipv6;
	wire proto_tcp = frame_info.ip_proto == `AKL_PROTO_TCP;
	wire proto_udp = frame_info.ip_proto == `AKL_PROTO_UDP;
	wire is_transport = is_ip && (proto_tcp || proto_udp);
	wire is_tcp = is_ip && proto_tcp;

	wire [8:0] l2_pay = {1'b0, frame_info.l2_pay_ofs};
	wire [8:0] l3_start = {1'b0, frame_info.l3_ofs};
	wire [8:0] l4_start = {1'b0, frame_info.l4_ofs};

	// Options are never parsed, so IPv4 payload sits at a fixed distance
	wire [8:0] ip_hdr_len = frame_info.is_ipv4 ? `AKL_IPV4_HDR_BYTES : `AKL_IPV6_HDR_BYTES;
	wire [8:0] ip_pay_start = l3_start + ip_hdr_len;

	// ======================================================================
	// Transport header fields
	logic [`AKL_TCP_HDR_BYTES*8-1:0] l4_hdr;

	akl_byte_window #(
		.FRAME_BYTES(FRAME_BYTES),
		.NBYTES(`AKL_TCP_HDR_BYTES)
	) u_l4_hdr (
		.frame(frame_data),
		.start(l4_start),
		.win(l4_hdr)
	);

	wire [15:0] sport = l4_hdr[111:96];
	wire [15:0] dport = l4_hdr[95:80];
	wire [31:0] tcp_seq = l4_hdr[79:48];
	wire [3:0] tcp_data_words = l4_hdr[15:12];
	wire [7:0] tcp_flags = l4_hdr[7:0];

	wire ports_equal = is_transport && (sport == dport);
	wire seq_zero = is_tcp && (tcp_seq == 32'h0000_0000);

	wire [8:0] tcp_hdr_len = {3'h0, tcp_data_words, 2'h0};
	wire [8:0] l4_hdr_len = is_tcp ? tcp_hdr_len : `AKL_UDP_HDR_BYTES;
	// Non-transport frames reuse this window for the bytes after IP
	wire [8:0] l4_pay_start = is_transport ? l4_start + l4_hdr_len : ip_pay_start;

	// ======================================================================
	// Payload windows
	logic [`AKL_IP_PAY_BYTES*8-1:0] ip_pay;
	logic [`AKL_L4_PAY_BYTES*8-1:0] l4_pay;

	akl_byte_window #(
		.FRAME_BYTES(FRAME_BYTES),
		.NBYTES(`AKL_IP_PAY_BYTES)
	) u_ip_pay (
		.frame(frame_data),
		.start(ip_pay_start),
		.win(ip_pay)
	);

	akl_byte_window #(
		.FRAME_BYTES(FRAME_BYTES),
		.NBYTES(`AKL_L4_PAY_BYTES)
	) u_l4_pay (
		.frame(frame_data),
		.start(l4_pay_start),
		.win(l4_pay)
	);

	// ======================================================================
	// OAM detection
	logic [15:0] oam_head;
	logic [`AKL_CCM_CNT_BYTES*8-1:0] ccm_counters;

	akl_byte_window #(
		.FRAME_BYTES(FRAME_BYTES),
		.NBYTES(2)
	) u_oam_head (
		.frame(frame_data),
		.start(l2_pay),
		.win(oam_head)
	);

	akl_byte_window #(
		.FRAME_BYTES(FRAME_BYTES),
		.NBYTES(`AKL_CCM_CNT_BYTES)
	) u_ccm_cnt (
		.frame(frame_data),
		.start(l2_pay + `AKL_CCM_CNT_OFS),
		.win(ccm_counters)
	);

	wire is_oam = frame_info.ethertype == `AKL_OAM_ETHERTYPE_KEY_FIELD;
	wire is_ccm = is_oam && (oam_head[7:0] == `AKL_CCM_OPCODE);
	wire counters_zero = is_ccm && (ccm_counters == '0);
	wire [2:0] oam_level = oam_head[15:13];
	wire [7:0] level_flags = 8'h01 << oam_level;
	wire [15:0] ethertype_key_field_field = is_oam ? {8'h00, level_flags} : frame_info.ethertype;

	// ======================================================================
	// Custom payload windows
	// Ethernet frames never expose their own L2 header to custom keys
	wire long_early = frame_info.is_eth && (frame_info.cust_long_ofs < frame_info.l2_pay_ofs);
	wire short_early = frame_info.is_eth && (frame_info.cust_short_ofs < frame_info.l2_pay_ofs);
	wire [8:0] cust_long_start = long_early ? l2_pay : {1'b0, frame_info.cust_long_ofs};
	wire [8:0] cust_short_start = short_early ? l2_pay : {1'b0, frame_info.cust_short_ofs};

	logic [`AKL_CUST_LONG_BYTES*8-1:0] cust_long;
	logic [`AKL_CUST_SHORT_BYTES*8-1:0] cust_short;

	akl_byte_window #(
		.FRAME_BYTES(FRAME_BYTES),
		.NBYTES(`AKL_CUST_LONG_BYTES)
	) u_cust_long (
		.frame(frame_data),
		.start(cust_long_start),
		.win(cust_long)
	);

	akl_byte_window #(
		.FRAME_BYTES(FRAME_BYTES),
		.NBYTES(`AKL_CUST_SHORT_BYTES)
	) u_cust_short (
		.frame(frame_data),
		.start(cust_short_start),
		.win(cust_short)
	);

	// ======================================================================
	// Range checkers
	logic [NUM_RANGES-1:0] range_hits;

	generate
		for (r = 0; r < NUM_RANGES; r++) begin : g_rng
			akl_range_checker u_chk (
				.rng_type(rng_type_reg[r]),
				.low(rng_bound_reg[r][15:0]),
				.high(rng_bound_reg[r][31:16]),
				.sport(sport),
				.dport(dport),
				.vid({4'h0, frame_info.vid}),
				.dscp({10'h000, frame_info.dscp}),
				.custom(frame_info.custom_rng),
				.is_transport(is_transport),
				.hit(range_hits[r])
			);
		end
	endgenerate

	// ======================================================================
	// Key assembly
	akl_pkg::akl_key_s key_next;

	always_comb begin
		key_next = '0;
		key_next.port_range_match_mask = 16'(range_hits);
		key_next.transport_type_flag = is_transport;
		key_next.ports_equal_flag = ports_equal;
		key_next.seq_zero_flag = seq_zero;
		if (is_tcp) begin
			key_next.tcp_fin_bit = tcp_flags[0];
			key_next.tcp_syn_bit = tcp_flags[1];
			key_next.tcp_rst_bit = tcp_flags[2];
			key_next.tcp_psh_bit = tcp_flags[3];
			key_next.tcp_ack_bit = tcp_flags[4];
			key_next.tcp_urg_bit = tcp_flags[5];
		end
		if (is_ip && !is_transport) begin
			key_next.ip_payload_window = ip_pay;
		end
		if (is_ip) begin
			key_next.transport_payload_window = l4_pay;
		end
		key_next.loss_counters_zero_flag = counters_zero;
		key_next.oam_ethertype_flag = is_oam;
		key_next.ethertype_key_field = ethertype_key_field_field;
		key_next.custom_payload_long = cust_long;
		key_next.custom_payload_short = cust_short;
	end

	wire key_take = frame_valid && ctrl_enable_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			key_reg <= '0;
			key_valid_reg <= 1'b0;
			key_count_reg <= 32'h0000_0000;
		end else begin
			key_valid_reg <= key_take;
			if (key_take) begin
				key_reg <= key_next;
				key_count_reg <= key_count_reg + 32'h0000_0001;
			end
		end
	end

endmodule

// file: hw/akl_params.svh
// Function
// - Sixteen range checkers build the key mask
// - Flag TRANSPORT_TYPE_FLAG frames whose ports are equal
// - Flag TCP frames with zero sequence number
// - IPv4 non-transport: 96 bits after header
// - TRANSPORT_TYPE_FLAG: 64 bits after transport header
// - Non-transport seven-tuple: eight bytes after IP
// - Flag CCM frames whose loss counters are zero
// - Flag frames with EtherType 0x8902
// - OAM frames: EtherType field carries level flags
// - Long custom key: 60 bytes at pointer
// - Short custom key: 24 bytes at location
// - Protocol 6 or 17 means transport frame
`ifndef AKL_PARAMS_SVH
`define AKL_PARAMS_SVH

// ==========================================================================
// Protocol constants
`define AKL_PROTO_TCP 8'h06
`define AKL_PROTO_UDP 8'h11
`define AKL_OAM_ETHERTYPE_KEY_FIELD 16'h8902
`define AKL_CCM_OPCODE 8'h01
`define AKL_IPV4_HDR_BYTES 9'h014
`define AKL_IPV6_HDR_BYTES 9'h028
`define AKL_UDP_HDR_BYTES 9'h008
`define AKL_CCM_CNT_OFS 9'h03A

// ==========================================================================
// Key field widths in bytes, and the range checker count
`define AKL_TCP_HDR_BYTES 14
`define AKL_IP_PAY_BYTES 12
`define AKL_L4_PAY_BYTES 8
`define AKL_CCM_CNT_BYTES 12
`define AKL_CUST_LONG_BYTES 60
`define AKL_CUST_SHORT_BYTES 24
`define AKL_NUM_RANGES 16

// ==========================================================================
// Register word offsets and reset values
`define AKL_REG_CTRL 7'h00
`define AKL_REG_KEY_COUNT 7'h01
`define AKL_REG_RNG_TYPE_BASE 7'h10
`define AKL_REG_RNG_BOUND_BASE 7'h20
`define AKL_CTRL_RESET 1'h1
`define AKL_RNG_BOUND_RESET 32'h0000_0000

`endif

// file: hw/akl_pkg.sv
package akl_pkg;

	typedef enum logic [2:0] {
		AKL_RNG_OFF,
		AKL_RNG_SPORT,
		AKL_RNG_DPORT,
		AKL_RNG_SPORT_OR_DPORT,
		AKL_RNG_VID,
		AKL_RNG_DSCP,
		AKL_RNG_CUSTOM
	} akl_rng_type_e;

	typedef struct packed {
		logic is_eth;
		logic is_ipv4;
		logic is_ipv6;
		logic [7:0] ip_proto;
		logic [15:0] ethertype;
		logic [7:0] l2_pay_ofs;
		logic [7:0] l3_ofs;
		logic [7:0] l4_ofs;
		logic [7:0] cust_long_ofs;
		logic [7:0] cust_short_ofs;
		logic [11:0] vid;
		logic [5:0] dscp;
		logic [15:0] custom_rng;
	} akl_frame_s;

	typedef struct packed {
		logic [15:0] port_range_match_mask;
		logic transport_type_flag;
		logic ports_equal_flag;
		logic seq_zero_flag;
		logic tcp_fin_bit;
		logic tcp_syn_bit;
		logic tcp_rst_bit;
		logic tcp_psh_bit;
		logic tcp_ack_bit;
		logic tcp_urg_bit;
		logic [95:0] ip_payload_window;
		logic [63:0] transport_payload_window;
		logic loss_counters_zero_flag;
		logic oam_ethertype_flag;
		logic [15:0] ethertype_key_field;
		logic [479:0] custom_payload_long;
		logic [191:0] custom_payload_short;
	} akl_key_s;

endpackage

// file: hw/akl_range_checker.sv
`timescale 1ns/100ps
// ==========================================================================
// One range checker: inclusive low..high compare on the selected input
module akl_range_checker (
	input wire logic [2:0] rng_type,
	input wire logic [15:0] low,
	input wire logic [15:0] high,
	input wire logic [15:0] sport,
	input wire logic [15:0] dport,
	input wire logic [15:0] vid,
	input wire logic [15:0] dscp,
	input wire logic [15:0] custom,
	input wire logic is_transport,
	output logic hit
);
	wire sport_in = (sport >= low) && (sport <= high) && is_transport;
	wire dport_in = (dport >= low) && (dport <= high) && is_transport;
	wire vid_in = (vid >= low) && (vid <= high);
	wire dscp_in = (dscp >= low) && (dscp <= high);
	wire custom_in = (custom >= low) && (custom <= high);

	always_comb begin
		case (akl_pkg::akl_rng_type_e'(rng_type))
			akl_pkg::AKL_RNG_SPORT: hit = sport_in;
			akl_pkg::AKL_RNG_DPORT: hit = dport_in;
			akl_pkg::AKL_RNG_SPORT_OR_DPORT: hit = sport_in || dport_in;
			akl_pkg::AKL_RNG_VID: hit = vid_in;
			akl_pkg::AKL_RNG_DSCP: hit = dscp_in;
			akl_pkg::AKL_RNG_CUSTOM: hit = custom_in;
			default: hit = 1'b0;
		endcase
	end
endmodule

// file: verification/akl_frame_src.sv
`timescale 1ns/100ps
// ====================
// Parser stand-in: one frame per call, then the lines go stale
module akl_frame_src #(
	parameter int FRAME_BYTES = 128
) (
	input wire logic clk,
	output logic frame_valid,
	output akl_pkg::akl_frame_s frame_info,
	output logic [FRAME_BYTES*8-1:0] frame_data
);
	initial begin
		frame_valid = 1'h0;
		frame_info = '0;
		frame_data = '0;
	end
	task automatic send(input akl_pkg::akl_frame_s fi, input logic [FRAME_BYTES*8-1:0] fd);
		@(posedge clk);
		frame_valid <= 1'h1;
		frame_info <= fi;
		frame_data <= fd;
		@(posedge clk);
		frame_valid <= 1'h0;
		// Inverted so a key built late can never match the old frame
		frame_info <= ~fi;
		frame_data <= ~fd;
	endtask
endmodule

// file: verification/akl_key_fields_properties.sv
`timescale 1ns/100ps
// ====================
// Port checks; en_reg mirrors the key enable bit as written over the bus
module akl_key_fields_properties #(
	parameter int FRAME_BYTES = 128,
	parameter int NUM_RANGES = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic frame_valid,
	input wire akl_pkg::akl_frame_s frame_info,
	input wire logic [FRAME_BYTES*8-1:0] frame_data,
	input wire akl_pkg::akl_key_s key_reg,
	input wire logic key_valid_reg,
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	logic en_reg;
	akl_pkg::akl_frame_s info_reg;
	wire ctrl_wr = avs_write && !avs_waitrequest && avs_address == 7'h00;
	wire is_ip = info_reg.is_ipv4 || info_reg.is_ipv6;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk) begin
		info_reg <= frame_info;
		if (!rst_n) begin
			en_reg <= 1'h1;
		end else if (ctrl_wr) begin
			en_reg <= avs_writedata[0];
		end
	end
	a_key_taken: assert property (frame_valid && en_reg |=> key_valid_reg)
		else $error("key missing");
	a_key_refused: assert property (frame_valid && !en_reg |=> !key_valid_reg)
		else $error("key while disabled");
	a_key_held: assert property (!key_valid_reg |-> $stable(key_reg))
		else $error("key changed alone");
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	a_bus_release: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer too long");
	a_read_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
		else $error("stale read data");
	a_transport_type: assert property (key_valid_reg |->
		key_reg.transport_type_flag == (is_ip && info_reg.ip_proto inside {8'h06, 8'h11}))
		else $error("type flag");
	a_ports_equal: assert property (key_valid_reg && !key_reg.transport_type_flag |->
		!key_reg.ports_equal_flag) else $error("port flag");
	a_tcp_flags: assert property (key_valid_reg && !(is_ip && info_reg.ip_proto == 8'h06) |->
		{key_reg.tcp_fin_bit, key_reg.tcp_syn_bit, key_reg.tcp_rst_bit, key_reg.tcp_psh_bit,
		key_reg.tcp_ack_bit, key_reg.tcp_urg_bit} == 6'h00) else $error("tcp");
	a_oam_flag: assert property (key_valid_reg |->
		key_reg.oam_ethertype_flag == (info_reg.ethertype == 16'h8902)) else $error("oam flag");
	a_oam_level: assert property (key_valid_reg && key_reg.oam_ethertype_flag |->
		$onehot({8'h00, key_reg.ethertype_key_field})) else $error("level field");
	a_loss_oam: assert property (key_valid_reg && key_reg.loss_counters_zero_flag |->
		key_reg.oam_ethertype_flag) else $error("loss flag");
endmodule
bind akl_key_fields akl_key_fields_properties #(
	.FRAME_BYTES(FRAME_BYTES), .NUM_RANGES(NUM_RANGES)
) u_props (
	.clk(clk), .rst_n(rst_n), .frame_valid(frame_valid), .frame_info(frame_info),
	.frame_data(frame_data), .key_reg(key_reg), .key_valid_reg(key_valid_reg),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest)
);

// file: verification/tb_top.sv
`timescale 1ns/100ps
// ====================
// Random frames with forced corner cases, registers over the slave bus
module tb_top;
	localparam int FB = 128;
	localparam logic [6:0] RA [5] = '{7'h00, 7'h01, 7'h05, 7'h10, 7'h2F};
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic frame_valid;
	akl_pkg::akl_frame_s frame_info;
	logic [FB*8-1:0] frame_data;
	akl_pkg::akl_key_s key_reg;
	logic key_valid_reg;
	logic [6:0] avs_address = 7'h00;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [2:0] typ [16];
	logic [15:0] lo [16];
	logic [15:0] hi [16];
	int err_count = 0;
	int comparisons = 0;
	always #5 clk = ~clk;
	akl_key_fields #(.FRAME_BYTES(FB)) dut (
		.clk(clk), .rst_n(rst_n), .frame_valid(frame_valid), .frame_info(frame_info),
		.frame_data(frame_data), .key_reg(key_reg), .key_valid_reg(key_valid_reg),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest)
	);
	akl_frame_src #(.FRAME_BYTES(FB)) src (
		.clk(clk), .frame_valid(frame_valid), .frame_info(frame_info),
		.frame_data(frame_data)
	);
	task automatic chk(input logic [479:0] seen, input logic [479:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (err_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		chk(n < 50, 1'h1);
	endtask
	function automatic logic [479:0] win(input logic [FB*8-1:0] fd, input int s, input int n);
		logic [479:0] r;
		r = '0;
		for (int k = 0; k < n; k++) r[8*(n-1-k)+:8] = (s + k < FB) ? fd[8*(s+k)+:8] : 8'h00;
		return r;
	endfunction
	function automatic logic inr(input int i, input logic [15:0] x);
		return x >= lo[i] && x <= hi[i];
	endfunction
	function automatic logic [15:0] exp_mask(input logic tt, input logic [15:0] sp, dp, v, d, c);
		logic [15:0] m;
		for (int i = 0; i < 16; i++) begin
			case (typ[i])
				3'h1: m[i] = tt && inr(i, sp);
				3'h2: m[i] = tt && inr(i, dp);
				3'h3: m[i] = tt && (inr(i, sp) || inr(i, dp));
				3'h4: m[i] = inr(i, v);
				3'h5: m[i] = inr(i, d);
				3'h6: m[i] = inr(i, c);
				default: m[i] = 1'h0;
			endcase
		end
		return m;
	endfunction
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up();
	end
	initial begin
		akl_pkg::akl_frame_s fi;
		logic [FB*8-1:0] fd;
		logic [31:0] rd;
		logic [15:0] sp;
		logic [15:0] dp;
		logic tt;
		int l4, hl, ipl, lvl, kind, cl, cs;
		void'($urandom(32'h8FD7));
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		bus(1'h1, 7'h05, 32'hFFFF_FFFF, rd);
		bus(1'h1, 7'h01, 32'h0000_0007, rd);
		for (int i = 0; i < 5; i++) begin
			bus(1'h0, RA[i], 32'h0, rd);
			chk(rd, i == 0);
		end
		// Every range code twice, 7 included; range 3 is a single value
		for (int i = 0; i < 16; i++) begin
			typ[i] = 3'(i % 8);
			lo[i] = 16'($urandom % 40);
			hi[i] = (i == 3) ? lo[i] : lo[i] + 16'($urandom % 30);
			bus(1'h1, 7'h10 + 7'(i), {29'h0, typ[i]}, rd);
			bus(1'h1, 7'h20 + 7'(i), {hi[i], lo[i]}, rd);
		end
		bus(1'h0, 7'h17, 32'h0, rd);
		chk(rd, 32'h7);
		for (int it = 0; it < 60; it++) begin
			kind = it % 4;
			for (int w = 0; w < FB / 4; w++) fd[32*w+:32] = $urandom;
			fi = '0;
			fi.is_eth = kind == 3;
			fi.is_ipv4 = kind == 0 || kind == 2;
			fi.is_ipv6 = kind == 1;
			fi.ethertype = (kind == 3) ? 16'h8902 : (kind == 1) ? 16'h86DD : 16'h0800;
			fi.ip_proto = (kind == 0) ? 8'h06 : (kind == 1) ? 8'h11 : (kind == 2) ? 8'(32 + it) : 8'h00;
			fi.l2_pay_ofs = 8'h0E;
			fi.l3_ofs = 8'h0E;
			ipl = fi.is_ipv6 ? 40 : 20;
			l4 = 14 + ipl;
			fi.l4_ofs = 8'(l4);
			hl = (kind == 1) ? 8 : 4 * (5 + it % 3);
			if (kind == 0) fd[8*(l4+12)+:8] = 8'(hl * 4);
			if (it % 3 == 0) fd[8*(l4+4)+:32] = 32'h0;
			fd[8*l4+:8] = 8'h00;
			fd[8*(l4+2)+:8] = 8'h00;
			fd[8*(l4+1)+:8] = 8'($urandom % 48);
			fd[8*(l4+3)+:8] = (it % 5 == 0) ? fd[8*(l4+1)+:8] : 8'($urandom % 48);
			sp = {8'h00, fd[8*(l4+1)+:8]};
			dp = {8'h00, fd[8*(l4+3)+:8]};
			lvl = $urandom % 8;
			fd[8*14+:8] = {3'(lvl), 5'h00};
			fd[8*15+:8] = (it % 8 == 7) ? 8'h03 : 8'h01;
			if (it % 16 != 11) fd[8*72+:96] = 96'h0;
			fi.vid = 12'($urandom % 48);
			fi.dscp = 6'($urandom);
			fi.custom_rng = 16'($urandom % 48);
			fi.cust_long_ofs = 8'($urandom % 70);
			fi.cust_short_ofs = 8'($urandom % 110);
			cl = (fi.is_eth && fi.cust_long_ofs < 14) ? 14 : fi.cust_long_ofs;
			cs = (fi.is_eth && fi.cust_short_ofs < 14) ? 14 : fi.cust_short_ofs;
			if (it == 30) begin
				bus(1'h1, 7'h00, 32'h0, rd);
				src.send(fi, fd);
				#1;
				chk(key_valid_reg, 1'h0);
				bus(1'h1, 7'h00, 32'h1, rd);
			end
			src.send(fi, fd);
			#1;
			tt = kind < 2;
			chk(key_valid_reg, 1'h1);
			chk(key_reg.port_range_match_mask,
				exp_mask(tt, sp, dp, {4'h0, fi.vid}, {10'h0, fi.dscp}, fi.custom_rng));
			chk(key_reg.transport_type_flag, tt);
			chk(key_reg.ports_equal_flag, tt && sp == dp);
			chk(key_reg.seq_zero_flag, kind == 0 && fd[8*(l4+4)+:32] == 32'h0);
			chk({key_reg.tcp_urg_bit, key_reg.tcp_ack_bit, key_reg.tcp_psh_bit,
				key_reg.tcp_rst_bit, key_reg.tcp_syn_bit, key_reg.tcp_fin_bit},
				(kind == 0) ? fd[8*(l4+13)+:6] : 6'h0);
			chk(key_reg.ip_payload_window, (kind == 2) ? win(fd, 34, 12) : 480'h0);
			chk(key_reg.transport_payload_window,
				tt ? win(fd, l4 + hl, 8) : (kind == 2) ? win(fd, 34, 8) : 480'h0);
			chk(key_reg.oam_ethertype_flag, kind == 3);
			chk(key_reg.ethertype_key_field,
				(kind == 3) ? {8'h00, 8'(1 << lvl)} : fi.ethertype);
			chk(key_reg.loss_counters_zero_flag, kind == 3 && it % 8 != 7 && it % 16 != 11);
			chk(key_reg.custom_payload_long, win(fd, cl, 60));
			chk(key_reg.custom_payload_short, win(fd, cs, 24));
		end
		bus(1'h0, 7'h01, 32'h0, rd);
		chk(rd, 32'h0000_003C);
		// Mid-run reset must clear the count and the range setup
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		bus(1'h0, 7'h01, 32'h0, rd);
		chk(rd, 32'h0000_0000);
		bus(1'h0, 7'h17, 32'h0, rd);
		chk(rd, 32'h0000_0000);
		bus(1'h0, 7'h00, 32'h0, rd);
		chk(rd, 32'h0000_0001);
		wrap_up();
	end
endmodule
